// file: spw_pkg.sv
// Package: register map, field layout, reset values and types of the six-phase PWM block
package spw_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] SPW_OFF_CTRL      = 12'h000;
    localparam logic [11:0] SPW_OFF_CYCLE     = 12'h004;
    localparam logic [11:0] SPW_OFF_DUTY_U    = 12'h008;
    localparam logic [11:0] SPW_OFF_DUTY_V    = 12'h00c;
    localparam logic [11:0] SPW_OFF_DUTY_W    = 12'h010;
    localparam logic [11:0] SPW_OFF_DEADTIME  = 12'h014;
    localparam logic [11:0] SPW_OFF_CULL      = 12'h018;
    localparam logic [11:0] SPW_OFF_STATUS    = 12'h01c;
    localparam logic [11:0] SPW_OFF_SHUTOFF   = 12'h020;

    // ==========================================================
    // Timer control register fields
    localparam int SPW_CTRL_RUN_BIT   = 0;
    localparam int SPW_CTRL_MODE_LSB  = 1;
    localparam int SPW_CTRL_ANYTIME   = 4;
    localparam int SPW_CTRL_INTERMIT  = 5;
    localparam logic [2:0] SPW_MODE_SIX_PHASE = 3'h7;

    // ==========================================================
    // Cull option register fields
    localparam int SPW_CULL_CREST_EN  = 7;
    localparam int SPW_CULL_VALLEY_EN = 6;

    // ==========================================================
    // Output shutoff control register fields
    localparam int SPW_SH_ENABLE   = 7;
    localparam int SPW_SH_CLR_COND = 6;
    localparam int SPW_SH_FALLING  = 5;
    localparam int SPW_SH_RISING   = 4;
    localparam int SPW_SH_TRIGGER  = 3;
    localparam int SPW_SH_CLEAR    = 2;
    localparam int SPW_SH_FLAG     = 0;

    // ==========================================================
    // Reset values and counter constants
    localparam logic [15:0] SPW_CYCLE_RESET = 16'hffff;
    localparam logic [15:0] SPW_DUTY_RESET  = 16'h0000;
    localparam logic [9:0]  SPW_DT_RESET    = 10'h000;
    localparam logic [7:0]  SPW_CULL_RESET  = 8'h00;
    localparam logic [15:0] SPW_VALLEY_CNT  = 16'h0001;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        SPW_IDLE = 3'b001,
        SPW_UP   = 3'b010,
        SPW_DOWN = 3'b100
    } spw_cnt_state_type;

    typedef struct packed {
        logic enable;
        logic clr_cond;
        logic falling;
        logic rising;
    } spw_shutoff_cfg_type;

    typedef struct packed {
        logic [2:0] value;
        logic [2:0] enable;
    } spw_pin_group_type;

endpackage : spw_pkg

// file: spw_six_phase_pwm.sv
// Six-phase PWM generator with dead time, buffered compares and output shutoff
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module spw_six_phase_pwm
    import spw_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Fault pin
    input  wire logic               motor_fault_input,
    // Gate driver pins
    output spw_pin_group_type       high_side_output,
    output spw_pin_group_type       low_side_output,
    // Carrier events
    output logic                    crest_irq,
    output logic                    valley_irq
);

    // ==========================================================
    // Declarations
    logic                   ctrl_run;
    logic [2:0]             timer_mode_field;
    logic                   ctrl_anytime;
    logic                   ctrl_intermittent;
    logic [15:0]            cycle_buf;
    logic [15:0]            cycle_act;
    logic [15:0]            duty_buf [0:2];
    logic [15:0]            duty_act [0:2];
    logic [9:0]             dead_time_compare;
    logic [7:0]             cull_buf;
    logic [7:0]             cull_act;
    logic                   batch_armed;
    logic [4:0]             cull_cnt;
    logic [15:0]            carrier_cnt;
    spw_cnt_state_type      cnt_state;
    spw_cnt_state_type      next_cnt_state;
    logic [15:0]            next_carrier_cnt;
    spw_shutoff_cfg_type    shutoff_cfg;
    logic                   shutoff_status_flag;
    logic                   next_flag;
    logic                   fault_sync1;
    logic                   fault_sync2;
    logic                   fault_prev;
    logic [2:0]             wave_now;
    logic [2:0]             hs_next;
    logic [2:0]             ls_next;
    logic [31:0]            next_prdata;

    // ==========================================================
    // APB decode
    wire apb_setup  = psel & ~penable;
    wire apb_write  = psel & penable & pwrite & pready;
    wire sel_ctrl   = (paddr == SPW_OFF_CTRL);
    wire sel_cycle  = (paddr == SPW_OFF_CYCLE);
    wire sel_du     = (paddr == SPW_OFF_DUTY_U);
    wire sel_dv     = (paddr == SPW_OFF_DUTY_V);
    wire sel_dw     = (paddr == SPW_OFF_DUTY_W);
    wire sel_dt     = (paddr == SPW_OFF_DEADTIME);
    wire sel_cull   = (paddr == SPW_OFF_CULL);
    wire sel_status = (paddr == SPW_OFF_STATUS);
    wire sel_shut   = (paddr == SPW_OFF_SHUTOFF);
    wire addr_hit   = sel_ctrl | sel_cycle | sel_du | sel_dv | sel_dw | sel_dt
                    | sel_cull | sel_status | sel_shut;
    wire [2:0] sel_duty = {sel_dw, sel_dv, sel_du};

    // ==========================================================
    // Carrier counter control
    wire running     = ctrl_run & (timer_mode_field == SPW_MODE_SIX_PHASE);
    wire dir_down    = (cnt_state == SPW_DOWN);
    wire crest_ev    = (cnt_state == SPW_UP) & (carrier_cnt == cycle_act);
    wire valley_ev   = dir_down & (carrier_cnt == SPW_VALLEY_CNT);
    wire [16:0] m_plus_one = {1'b0, cycle_act} + 17'h00001;

    always_comb begin
        next_cnt_state   = cnt_state;
        next_carrier_cnt = carrier_cnt;
        unique case (cnt_state)
            SPW_IDLE: begin
                next_carrier_cnt = 16'h0000;
                if (running) begin
                    next_cnt_state = SPW_UP;
                end
            end
            SPW_UP: begin
                next_carrier_cnt = carrier_cnt + 16'h0001;
                if (crest_ev) begin
                    next_cnt_state = SPW_DOWN;
                end
            end
            SPW_DOWN: begin
                if (valley_ev) begin
                    next_cnt_state   = SPW_UP;
                    next_carrier_cnt = 16'h0000;
                end else begin
                    next_carrier_cnt = carrier_cnt - 16'h0001;
                end
            end
            default: begin
                next_cnt_state   = SPW_IDLE;
                next_carrier_cnt = 16'h0000;
            end
        endcase
        if (!running) begin
            next_cnt_state   = SPW_IDLE;
            next_carrier_cnt = 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_state   <= SPW_IDLE;
            carrier_cnt <= 16'h0000;
        end else begin
            cnt_state   <= next_cnt_state;
            carrier_cnt <= next_carrier_cnt;
        end
    end

    // ==========================================================
    // Interrupt culling and transfer timing
    wire [4:0] cull_num  = cull_act[4:0];
    wire cull_src        = (crest_ev & cull_act[SPW_CULL_CREST_EN])
                         | (valley_ev & cull_act[SPW_CULL_VALLEY_EN]);
    wire cull_fire       = cull_src & (cull_cnt == cull_num);
    wire direct_load     = ctrl_anytime | ~running;
    wire xfer_point      = ctrl_intermittent ? cull_fire : (crest_ev | valley_ev);
    wire xfer_now        = running & ~ctrl_anytime & batch_armed & xfer_point;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cull_cnt   <= 5'h00;
            crest_irq  <= 1'b0;
            valley_irq <= 1'b0;
        end else begin
            if (!running || cull_fire) begin
                cull_cnt <= 5'h00;
            end else if (cull_src) begin
                cull_cnt <= cull_cnt + 5'h01;
            end
            crest_irq  <= cull_fire & crest_ev;
            valley_irq <= cull_fire & valley_ev;
        end
    end

    // ==========================================================
    // Timer configuration and buffered compare registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_run          <= 1'b0;
            timer_mode_field  <= 3'h0;
            ctrl_anytime      <= 1'b0;
            ctrl_intermittent <= 1'b0;
            dead_time_compare <= SPW_DT_RESET;
        end else if (apb_write && sel_ctrl) begin
            ctrl_run          <= pwdata[SPW_CTRL_RUN_BIT];
            timer_mode_field  <= pwdata[SPW_CTRL_MODE_LSB +: 3];
            ctrl_anytime      <= pwdata[SPW_CTRL_ANYTIME];
            ctrl_intermittent <= pwdata[SPW_CTRL_INTERMIT];
        end else if (apb_write && sel_dt) begin
            dead_time_compare <= pwdata[9:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_buf   <= SPW_CYCLE_RESET;
            cycle_act   <= SPW_CYCLE_RESET;
            cull_buf    <= SPW_CULL_RESET;
            cull_act    <= SPW_CULL_RESET;
            batch_armed <= 1'b0;
        end else begin
            if (apb_write && sel_cycle) begin
                cycle_buf <= pwdata[15:0];
            end
            if (apb_write && sel_cycle && direct_load) begin
                cycle_act <= pwdata[15:0];
            end else if (xfer_now) begin
                cycle_act <= cycle_buf;
            end
            if (apb_write && sel_cull) begin
                cull_buf <= pwdata[7:0];
            end
            if (apb_write && sel_cull && direct_load) begin
                cull_act <= pwdata[7:0];
            end else if (xfer_now) begin
                cull_act <= cull_buf;
            end
            // Phase U duty write arms the batch transfer
            if (apb_write && sel_du && !direct_load) begin
                batch_armed <= 1'b1;
            end else if (xfer_now || direct_load) begin
                batch_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                duty_buf[i] <= SPW_DUTY_RESET;
                duty_act[i] <= SPW_DUTY_RESET;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (apb_write && sel_duty[i]) begin
                    duty_buf[i] <= pwdata[15:0];
                end
                if (apb_write && sel_duty[i] && direct_load) begin
                    duty_act[i] <= pwdata[15:0];
                end else if (xfer_now) begin
                    duty_act[i] <= duty_buf[i];
                end
            end
        end
    end

    // ==========================================================
    // Phase waves and dead-time counters
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : g_phase
            logic       wave_q;
            logic [9:0] dt_cnt;
            logic [9:0] next_dt;
            wire        over = ({1'b0, duty_act[p]} > m_plus_one);
            // Up: high from duty to M; down: high above duty; a duty above M+1 holds the wave high for the whole down count
            wire        cmp_hi = dir_down ? (carrier_cnt > duty_act[p])
                                          : (carrier_cnt >= duty_act[p]);
            assign wave_now[p] = running & (over ? dir_down : cmp_hi);
            assign next_dt = (wave_now[p] != wave_q) ? 10'h000
                           : (dt_cnt >= dead_time_compare) ? dt_cnt
                           : dt_cnt + 10'h001;
            wire        dt_done = (next_dt >= dead_time_compare);
            assign hs_next[p] = wave_now[p] & dt_done;
            assign ls_next[p] = running & ~wave_now[p] & dt_done;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wave_q <= 1'b0;
                    dt_cnt <= 10'h000;
                end else begin
                    wave_q <= wave_now[p];
                    dt_cnt <= next_dt;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Fault pin synchroniser and shutoff control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_sync1 <= 1'b0;
            fault_sync2 <= 1'b0;
            fault_prev  <= 1'b0;
        end else begin
            fault_sync1 <= motor_fault_input;
            fault_sync2 <= fault_sync1;
            fault_prev  <= fault_sync2;
        end
    end

    wire fault_active = (shutoff_cfg.rising & fault_sync2)
                      | (shutoff_cfg.falling & ~fault_sync2);
    wire fault_edge   = shutoff_cfg.enable
                      & ((shutoff_cfg.rising & fault_sync2 & ~fault_prev)
                      | (shutoff_cfg.falling & ~fault_sync2 & fault_prev));
    wire shut_wr      = apb_write & sel_shut;
    wire trig_ok      = shut_wr & shutoff_cfg.enable & pwdata[SPW_SH_TRIGGER]
                      & ~fault_active;
    wire clr_ok       = shut_wr & shutoff_cfg.enable & pwdata[SPW_SH_CLEAR]
                      & ~(shutoff_cfg.clr_cond & fault_active);

    always_comb begin
        next_flag = shutoff_status_flag;
        if (!shutoff_cfg.enable) begin
            next_flag = 1'b0;
        end else if (fault_edge || trig_ok) begin
            next_flag = 1'b1;
        end else if (clr_ok) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutoff_cfg         <= '0;
            shutoff_status_flag <= 1'b0;
        end else begin
            if (shut_wr) begin
                shutoff_cfg.enable   <= pwdata[SPW_SH_ENABLE];
                shutoff_cfg.clr_cond <= pwdata[SPW_SH_CLR_COND];
                shutoff_cfg.falling  <= pwdata[SPW_SH_FALLING];
                shutoff_cfg.rising   <= pwdata[SPW_SH_RISING];
            end
            shutoff_status_flag <= next_flag;
        end
    end

    // ==========================================================
    // Pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_output <= '0;
            low_side_output  <= '0;
        end else begin
            high_side_output.value  <= hs_next;
            low_side_output.value   <= ls_next;
            high_side_output.enable <= {3{~next_flag}};
            low_side_output.enable  <= {3{~next_flag}};
        end
    end

    // ==========================================================
    // APB read and answer
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (1'b1)
            sel_ctrl:   next_prdata[5:0] = {ctrl_intermittent, ctrl_anytime,
                                            timer_mode_field, ctrl_run};
            sel_cycle:  next_prdata[15:0] = cycle_buf;
            sel_du:     next_prdata[15:0] = duty_buf[0];
            sel_dv:     next_prdata[15:0] = duty_buf[1];
            sel_dw:     next_prdata[15:0] = duty_buf[2];
            sel_dt:     next_prdata[9:0]  = dead_time_compare;
            sel_cull:   next_prdata[7:0]  = cull_buf;
            sel_status: next_prdata[16:0] = {dir_down, carrier_cnt};
            sel_shut:   next_prdata[7:0]  = {shutoff_cfg, 3'h0,
                                             shutoff_status_flag};
            default:    next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_hit;
            if (apb_setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule : spw_six_phase_pwm

// file: spw_six_phase_pwm_assertions.sv
// Checker: bus, shutoff and carrier properties of the six-phase PWM block
`timescale 1ns/1ps
module spw_six_phase_pwm_chk
    import spw_pkg::*;
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Pins and events
    input wire logic              motor_fault_input,
    input wire spw_pin_group_type high_side_output,
    input wire spw_pin_group_type low_side_output,
    input wire logic              crest_irq,
    input wire logic              valley_irq
);
    // ==========================================================
    // Shadow of shutoff setup, cycle value and crest spacing
    spw_shutoff_cfg_type cfg;
    logic [15:0]         cyc_m;
    logic [17:0]         gap;
    logic [1:0]          seen;
    wire                 wr_done = psel && penable && pready && pwrite;
    wire                 sh_wr   = wr_done && (paddr == SPW_OFF_SHUTOFF);
    wire                 all_on  = &{high_side_output.enable, low_side_output.enable};
    wire                 all_off = ~|{high_side_output.enable, low_side_output.enable};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg   <= '0;
            cyc_m <= SPW_CYCLE_RESET;
            gap   <= 18'h0;
            seen  <= 2'h0;
        end else begin
            cfg   <= sh_wr ? spw_shutoff_cfg_type'(pwdata[7:4]) : cfg;
            cyc_m <= (wr_done && paddr == SPW_OFF_CYCLE) ? pwdata[15:0] : cyc_m;
            gap   <= crest_irq ? 18'h1 : gap + 18'h1;
            seen  <= wr_done ? 2'h0 : seen + {1'b0, crest_irq && seen != 2'h2};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Sequences and properties
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_trigger;
        sh_wr && cfg.enable && !cfg.rising && !cfg.falling && pwdata[7] && pwdata[3];
    endsequence
    sequence s_clear;
        sh_wr && cfg.enable && !cfg.clr_cond && pwdata[7] && pwdata[2] && !pwdata[3];
    endsequence
    property p_pready_after_setup; s_setup |=> pready; endproperty
    property p_pready_pulse; pready |=> !pready; endproperty
    property p_err_with_ready; pslverr |-> pready; endproperty
    property p_trigger; s_trigger |=> ##1 all_off; endproperty
    property p_clear; s_clear |=> ##1 all_on; endproperty
    property p_disable; sh_wr && !pwdata[7] |=> ##1 all_on; endproperty
    property p_fault_edge;
        cfg.enable && ((cfg.rising && $rose(motor_fault_input))
            || (cfg.falling && $fell(motor_fault_input))) |-> ##[2:6] all_off;
    endproperty
    property p_complement;
        (high_side_output.value & low_side_output.value) == 3'h0;
    endproperty
    property p_crest_pulse; crest_irq |-> !valley_irq ##1 !crest_irq; endproperty
    property p_period; crest_irq && seen == 2'h2 |-> gap == 18'(2 * (cyc_m + 17'h1)); endproperty
    a_pready_after_setup: assert property (p_pready_after_setup) else $error("no ready");
    a_pready_pulse: assert property (p_pready_pulse) else $error("ready too long");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    a_trigger: assert property (p_trigger) else $error("trigger kept pins");
    a_clear: assert property (p_clear) else $error("clear kept hi-z");
    a_disable: assert property (p_disable) else $error("disabled yet hi-z");
    a_fault_edge: assert property (p_fault_edge) else $error("edge missed");
    a_complement: assert property (p_complement) else $error("overlap");
    a_crest_pulse: assert property (p_crest_pulse) else $error("crest pulse bad");
    a_period: assert property (p_period) else $error("carrier period bad");
endmodule : spw_six_phase_pwm_chk

bind spw_six_phase_pwm spw_six_phase_pwm_chk u_spw_six_phase_pwm_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_fault_input(motor_fault_input), .high_side_output(high_side_output),
    .low_side_output(low_side_output), .crest_irq(crest_irq), .valley_irq(valley_irq));

// file: spw_gate_model.sv
// Partner model: fault comparator and gate drivers with pull-downs
`timescale 1ns/1ps
module spw_gate_model
    import spw_pkg::*;
(
    // Fault request from the bench
    input  wire logic              fault_req,
    // Power stage side
    input  wire spw_pin_group_type high_side_output,
    input  wire spw_pin_group_type low_side_output,
    output logic                   motor_fault_input,
    output logic [2:0]             gate_hi,
    output logic [2:0]             gate_lo
);
    // Comparator lags the request, off the clock grid
    initial motor_fault_input = 1'b0;
    always @(fault_req) motor_fault_input <= #3 fault_req;
    // Released driver inputs fall to the pull-down level
    assign gate_hi = high_side_output.value & high_side_output.enable;
    assign gate_lo = low_side_output.value & low_side_output.enable;
endmodule : spw_gate_model

// file: tb_spw_six_phase_pwm.sv
// Testbench: register, shutoff and carrier scenarios for the six-phase PWM block
`timescale 1ns/1ps
module tb_spw_six_phase_pwm
    import spw_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, fault_req, pready, pslverr, perr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              crest_irq, valley_irq, motor_fault_input;
    spw_pin_group_type high_side_output, low_side_output;
    logic [2:0]        gate_hi, gate_lo;
    logic [15:0]       m;
    int                mismatches = 0, num_checks = 0, cycles = 0, seed = 82;
    localparam int     DT = 3;
    always #4 pclk = ~pclk;
    spw_six_phase_pwm u_spw_six_phase_pwm (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .motor_fault_input(motor_fault_input),
        .high_side_output(high_side_output), .low_side_output(low_side_output),
        .crest_irq(crest_irq), .valley_irq(valley_irq));
    spw_gate_model u_spw_gate_model (.fault_req(fault_req), .high_side_output(high_side_output),
        .low_side_output(low_side_output), .motor_fault_input(motor_fault_input),
        .gate_hi(gate_hi), .gate_lo(gate_lo));
    // ==========================================================
    // Reporting
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    // ==========================================================
    // Bus and expectation helpers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] sh_exp(input logic [3:0] cfg, input logic flag);
        return {24'h0, cfg, 3'b000, flag};
    endfunction : sh_exp
    task automatic flag_is(input logic [3:0] cfg, input logic flag);
        apb(1'b0, SPW_OFF_SHUTOFF, 32'h0);
        check(rd, sh_exp(cfg, flag));
        check({26'h0, high_side_output.enable, low_side_output.enable}, flag ? 0 : 32'h3f);
    endtask : flag_is
    task automatic shut(input logic [7:0] wv, input logic flag);
        apb(1'b1, SPW_OFF_SHUTOFF, {24'h0, wv});
        flag_is(wv[7:4], flag);
    endtask : shut
    task automatic wait_crest(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (crest_irq !== 1'b1 && n < 1000);
    endtask : wait_crest
    task automatic run_pwm(input logic [15:0] mv, input logic [15:0] du);
        int n, hi, lo, v, e;
        apb(1'b1, SPW_OFF_CTRL, 32'h0);
        apb(1'b1, SPW_OFF_CYCLE, {16'h0, mv});
        apb(1'b1, SPW_OFF_DUTY_U, {16'h0, du});
        apb(1'b1, SPW_OFF_DEADTIME, DT);
        apb(1'b1, SPW_OFF_CULL, 32'hc0);
        apb(1'b1, SPW_OFF_CTRL, {28'h0, SPW_MODE_SIX_PHASE, 1'b1});
        wait_crest(n);
        wait_crest(n);
        {n, hi, lo, v} = '0;
        do begin
            @(posedge pclk);
            n++;
            hi += gate_hi[0];
            lo += gate_lo[0];
            v += valley_irq;
        end while (crest_irq !== 1'b1 && n < 1000);
        check(n, 2 * (mv + 1));
        check(v, 1);
        e = (du == 0) ? n : (du > mv) ? 0 : 2 * (mv + 1 - du) - DT;
        check(hi, e);
        check(lo, (du == 0) ? 0 : (du > mv) ? n : n - 2 * DT - e);
        apb(1'b0, SPW_OFF_STATUS, 32'h0);
        check(rd[16] ? (rd[15:0] >= 1 && rd[15:0] <= mv + 1) : (rd[15:0] <= mv), 1);
        // Batch rewrite: new cycle lands once phase U duty is written
        apb(1'b1, SPW_OFF_CYCLE, {16'h0, mv + 16'h1});
        apb(1'b1, SPW_OFF_DUTY_U, {16'h0, du});
        repeat (3) wait_crest(n);
        check(n, 2 * (mv + 2));
        apb(1'b1, SPW_OFF_CTRL, 32'h0);
    endtask : run_pwm
    // ==========================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, fault_req, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        flag_is(4'h0, 1'b0);
        apb(1'b0, SPW_OFF_CYCLE, 32'h0);
        check(rd, {16'h0, SPW_CYCLE_RESET});
        apb(1'b0, 12'h024, 32'h0);
        check({perr, rd[30:0]}, 32'h8000_0000);
        shut(8'h80, 1'b0);
        shut(8'h88, 1'b1);
        shut(8'h84, 1'b0);
        shut(8'h88, 1'b1);
        shut(8'h00, 1'b0);
        shut(8'h08, 1'b0);
        shut(8'h04, 1'b0);
        shut(8'h10, 1'b0);
        shut(8'h90, 1'b0);
        fault_req <= 1'b1;
        repeat (8) @(posedge pclk);
        flag_is(4'h9, 1'b1);
        shut(8'h94, 1'b0);
        shut(8'h98, 1'b0);
        fault_req <= 1'b0;
        shut(8'h50, 1'b0);
        shut(8'hd0, 1'b0);
        fault_req <= 1'b1;
        repeat (8) @(posedge pclk);
        flag_is(4'hd, 1'b1);
        shut(8'hd4, 1'b1);
        fault_req <= 1'b0;
        repeat (4) @(posedge pclk);
        shut(8'hd4, 1'b0);
        shut(8'h20, 1'b0);
        fault_req <= 1'b1;
        shut(8'ha0, 1'b0);
        fault_req <= 1'b0;
        repeat (8) @(posedge pclk);
        flag_is(4'ha, 1'b1);
        shut(8'ha4, 1'b0);
        shut(8'h00, 1'b0);
        run_pwm(16'h0002, 16'h0000);
        m = 16'h2 + 16'($random(seed) & 32'h1f);
        run_pwm(m, m + 16'h1);
        m = 16'h10 + 16'($random(seed) & 32'hf);
        run_pwm(m, (m >> 1) + 16'($random(seed) & 32'h3));
        stop_test();
    end
endmodule : tb_spw_six_phase_pwm
